// *** logic/serial_load_consts.vh ***
// Constants for the synthesizer serial load port
`ifndef SERIAL_LOAD_CONSTS_VH
`define SERIAL_LOAD_CONSTS_VH
`define WORD_W          24
`define SEL_HI_BIT      1
`define SEL_LO_BIT      0
`define SEL_CONTROL     2'h0
`define SEL_REFCNT      2'h1
`define SEL_FBCNT       2'h2
`define SEL_TEST        2'h3
`define NUM_LATCHES     4
`define WORD_ZERO       24'h000000
`define CTL_RESET       24'h000000
`define MUX_W           3
`define MUX_LSB         5
`define PD1_BIT         20
`define PD2_BIT         21
`define MUX_TRISTATE    3'h0
`define MUX_DLOCK       3'h1
`define MUX_NDIV        3'h2
`define MUX_DVDD        3'h3
`define MUX_RDIV        3'h4
`define MUX_ALOCK       3'h5
`define MUX_SDO         3'h6
`define MUX_DGND        3'h7
`endif

// *** logic/latch_bank.v ***
// Four word latch bank with registered read ports
`timescale 1ns/1ps
`include "serial_load_consts.vh"
module latch_bank (
    input  wire                 ref_clk_in,
    input  wire                 rst_n_in,
    input  wire                 wr_en_in,
    input  wire [1:0]           wr_sel_in,
    input  wire [`WORD_W-1:0]   wr_data_in,
    output reg  [`WORD_W-1:0]   control_out,
    output reg  [`WORD_W-1:0]   ref_count_out,
    output reg  [`WORD_W-1:0]   fb_count_out,
    output reg  [`WORD_W-1:0]   test_out
);
    // One latch written per load; others hold
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            control_out   <= `CTL_RESET;
            ref_count_out <= `WORD_ZERO;
            fb_count_out  <= `WORD_ZERO;
            test_out      <= `WORD_ZERO;
        end
        else if (wr_en_in)
        begin
            case (wr_sel_in) // [R3] [R7]
                `SEL_CONTROL: control_out   <= wr_data_in;
                `SEL_REFCNT:  ref_count_out <= wr_data_in;
                `SEL_FBCNT:   fb_count_out  <= wr_data_in;
                default:      test_out      <= wr_data_in;
            endcase
        end
    end
endmodule

// *** logic/synth_serial_load_port.v ***
// Three-wire serial load port of a frequency synthesizer, with power-down and monitor select
//
// Overview of operation
// [R1] Shift data on each serial clock rise
// [R2] Host sends MSB first; LSBs select latch
// [R3] Strobe rise copies word into one latch
// [R4] Chip enable low: power down, pump tristated
// [R5] Chip enable high: software power-down still applies
// [R6] Monitor shows lock, RF divide or reference
// [R7] Select 00 control,01 ref,10 feedback,11 test
// [R8] Host never writes the test latch; the bench writes it once on purpose, and the bank stores it
// [R9] Power-up order: reference, control, feedback
// [R10] Extra clocks keep only last 24 bits
//
// Timing through the block, counted in reference clock edges after a pin
// changes at edge 0:
//   edge 1  first synchroniser stage holds the pin
//   edge 2  second stage holds it; edge detect compares with the old copy
//   edge 3  shift register steps, or the latch bank takes the word
//   edge 4  word outputs, band-select pulse and soft power-down effect update; chip enable reaches power and pump outputs at edge 3
// The serial clock is only sampled, so each of its phases must cover at
// least two reference cycles. A faster host loses edges silently.
//
// Data and serial clock pass through synchronisers of equal depth, so the
// relation between them at the pins is kept in the sampled copies. Data
// therefore needs to be steady for two reference cycles around each rise.
//
// The load strobe is synchronised the same way. A strobe that rises less
// than one cycle after the last serial clock rise may load the word
// before its final bit has been shifted in.
//
// Words addressed to the test latch are stored in the bank but drive no
// output, so a stray test write cannot disturb the synthesizer settings.
//
// Power state follows the chip enable pin and the two soft power-down bits
// of the control word; either bit set keeps the block down even with the
// pin high. The pump output is released whenever the block is down.
//
// Band selection restarts on every feedback latch load. The start pulse is
// delayed to appear in the same cycle as the new feedback word at the
// outputs, so a consumer may take both together.
`timescale 1ns/1ps
`include "serial_load_consts.vh"
module synth_serial_load_port (
    input  wire                 ref_clk_in,
    input  wire                 rst_n_in,
    input  wire                 serial_clk_in,
    input  wire                 serial_data_in,
    input  wire                 load_strobe_in,
    input  wire                 chip_enable_in,
    input  wire                 lock_detect_in,
    input  wire                 analog_lock_in,
    input  wire                 rf_div_in,
    input  wire                 ref_div_in,
    input  wire                 pump_up_in,
    input  wire                 pump_dn_in,
    output reg                  monitor_output_out,
    output reg                  monitor_output_oe_out,
    output reg                  charge_pump_output_out,
    output reg                  charge_pump_output_oe_out,
    output reg                  powered_up_out,
    output reg  [`WORD_W-1:0]   control_word_out,
    output reg  [`WORD_W-1:0]   ref_count_word_out,
    output reg  [`WORD_W-1:0]   fb_count_word_out,
    output reg                  band_select_start_out
);
    // Two-stage synchronisers for every pin from outside this clock except the pump requests
    reg [1:0] sclk_sync_q;
    reg [1:0] sdat_sync_q;
    reg [1:0] strobe_sync_q;
    reg [1:0] ce_sync_q;
    reg [1:0] lock_sync_q;
    reg [1:0] alock_sync_q;
    reg [1:0] rfdiv_sync_q;
    reg [1:0] refdiv_sync_q;
    reg       sclk_prev_q;
    reg       strobe_prev_q;

    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            sclk_sync_q   <= 2'h0;
            sdat_sync_q   <= 2'h0;
            strobe_sync_q <= 2'h0;
            ce_sync_q     <= 2'h0;
            lock_sync_q   <= 2'h0;
            alock_sync_q  <= 2'h0;
            rfdiv_sync_q  <= 2'h0;
            refdiv_sync_q <= 2'h0;
            sclk_prev_q   <= 1'b0;
            strobe_prev_q <= 1'b0;
        end
        else
        begin
            sclk_sync_q   <= {sclk_sync_q[0], serial_clk_in};
            sdat_sync_q   <= {sdat_sync_q[0], serial_data_in};
            strobe_sync_q <= {strobe_sync_q[0], load_strobe_in};
            ce_sync_q     <= {ce_sync_q[0], chip_enable_in};
            lock_sync_q   <= {lock_sync_q[0], lock_detect_in};
            alock_sync_q  <= {alock_sync_q[0], analog_lock_in};
            rfdiv_sync_q  <= {rfdiv_sync_q[0], rf_div_in};
            refdiv_sync_q <= {refdiv_sync_q[0], ref_div_in};
            sclk_prev_q   <= sclk_sync_q[1];
            strobe_prev_q <= strobe_sync_q[1];
        end
    end

    // Edge detection on the synchronised copies only
    wire sclk_rise_w   = sclk_sync_q[1] & ~sclk_prev_q;
    wire strobe_rise_w = strobe_sync_q[1] & ~strobe_prev_q;
    wire ce_w          = ce_sync_q[1];

    // Shift register; data is sampled with the clock, both delayed equally,
    // so setup/hold margin at the pins carries over to the samples
    reg [`WORD_W-1:0] shift_q;
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            shift_q <= `WORD_ZERO;
        else if (sclk_rise_w)
            shift_q <= {shift_q[`WORD_W-2:0], sdat_sync_q[1]}; // [R1] [R2] [R10]
    end

    // Latch select decode, used for the bank write and band-select trigger
    function [1:0] latch_sel;
        input [`WORD_W-1:0] word;
        begin
            latch_sel = {word[`SEL_HI_BIT], word[`SEL_LO_BIT]}; // [R7]
        end
    endfunction

    wire [`WORD_W-1:0] ctl_w;
    wire [`WORD_W-1:0] refc_w;
    wire [`WORD_W-1:0] fbc_w;

    // The bank latches even test words; the test latch drives nothing here
    latch_bank u_latch_bank (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .wr_en_in      (strobe_rise_w),
        .wr_sel_in     (latch_sel(shift_q)),
        .wr_data_in    (shift_q),
        .control_out   (ctl_w),
        .ref_count_out (refc_w),
        .fb_count_out  (fbc_w),
        .test_out      ()
    );

    // Power state: hardware enable gated by software power-down bits
    wire soft_pd_w = ctl_w[`PD1_BIT] | ctl_w[`PD2_BIT];
    wire active_w  = ce_w & ~soft_pd_w; // [R4] [R5]

    // Monitor source selection from the control latch
    reg       mon_d;
    reg       mon_oe_d;
    always @*
    begin
        mon_d    = 1'b0;
        mon_oe_d = 1'b1;
        case (ctl_w[`MUX_LSB+`MUX_W-1:`MUX_LSB]) // [R6]
            `MUX_TRISTATE: mon_oe_d = 1'b0;
            `MUX_DLOCK:    mon_d = lock_sync_q[1];
            `MUX_NDIV:     mon_d = rfdiv_sync_q[1];
            `MUX_DVDD:     mon_d = 1'b1;
            `MUX_RDIV:     mon_d = refdiv_sync_q[1];
            `MUX_ALOCK:    // Open drain: only ever pulls low
            begin
                mon_d    = 1'b0;
                mon_oe_d = ~alock_sync_q[1];
            end
            `MUX_SDO:      mon_d = shift_q[`WORD_W-1];
            `MUX_DGND:     mon_d = 1'b0;
            default:       mon_d = 1'b0;
        endcase
    end

    // Feedback load marker; one cycle of delay aligns it with fb_count_word_out
    wire fb_load_w = strobe_rise_w & (latch_sel(shift_q) == `SEL_FBCNT);
    reg  band_pend_q;
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            band_pend_q <= 1'b0;
        else
            band_pend_q <= fb_load_w; // [R3]
    end

    // Pump next values: driven only when active with exactly one request
    wire pump_d    = pump_up_in & ~pump_dn_in;
    wire pump_oe_d = active_w & (pump_up_in ^ pump_dn_in); // [R4]

    // Registered outputs; pump released whenever powered down
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            monitor_output_out        <= 1'b0;
            monitor_output_oe_out     <= 1'b0;
            charge_pump_output_out    <= 1'b0;
            charge_pump_output_oe_out <= 1'b0;
            powered_up_out            <= 1'b0;
            control_word_out          <= `WORD_ZERO;
            ref_count_word_out        <= `WORD_ZERO;
            fb_count_word_out         <= `WORD_ZERO;
            band_select_start_out     <= 1'b0;
        end
        else
        begin
            monitor_output_out        <= mon_d;
            monitor_output_oe_out     <= mon_oe_d;
            charge_pump_output_out    <= pump_d;
            charge_pump_output_oe_out <= pump_oe_d; // [R4]
            powered_up_out            <= active_w; // [R5]
            control_word_out          <= ctl_w;
            ref_count_word_out        <= refc_w;
            fb_count_word_out         <= fbc_w;
            // Feedback latch write restarts band selection
            band_select_start_out     <= band_pend_q;
        end
    end
endmodule

// *** verification/synth_serial_load_port_sva.sv ***
// Checker for the serial load port outputs
`timescale 1ns/1ps
`include "serial_load_consts.vh"
module port_checker (
    input wire               ref_clk_in,
    input wire               rst_n_in,
    input wire               chip_enable_in,
    input wire               pump_up_in,
    input wire               pump_dn_in,
    input wire               monitor_output_out,
    input wire               monitor_output_oe_out,
    input wire               charge_pump_output_out,
    input wire               charge_pump_output_oe_out,
    input wire               powered_up_out,
    input wire [`WORD_W-1:0] control_word_out,
    input wire [`WORD_W-1:0] ref_count_word_out,
    input wire [`WORD_W-1:0] fb_count_word_out,
    input wire               band_select_start_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Five cycles cover the pin synchroniser plus the output register
    pump_hiz_a: assert property (!chip_enable_in [*5] |-> !charge_pump_output_oe_out)
        else $error("pump driven while chip disabled");
    power_off_a: assert property (!chip_enable_in [*5] |-> !powered_up_out)
        else $error("powered while chip disabled");
    soft_down_a: assert property (control_word_out[`PD1_BIT] [*3] |-> !powered_up_out)
        else $error("powered despite soft power-down");
    pump_one_a: assert property (charge_pump_output_oe_out |-> $past(pump_up_in ^ pump_dn_in))
        else $error("pump driven without a single request");
    pump_dir_a: assert property (charge_pump_output_oe_out |-> charge_pump_output_out == $past(pump_up_in))
        else $error("pump direction wrong");
    one_latch_a: assert property ($changed(control_word_out) |-> $stable(ref_count_word_out)
        && $stable(fb_count_word_out)) else $error("two latches loaded at once");
    band_pulse_a: assert property ($changed(fb_count_word_out) |-> band_select_start_out ##1
        !band_select_start_out) else $error("band start pulse wrong");
    mux_low_a: assert property (control_word_out[7:5] == `MUX_DGND [*3] |->
        monitor_output_oe_out && !monitor_output_out) else $error("monitor not low");
    mux_off_a: assert property (control_word_out[7:5] == `MUX_TRISTATE [*3] |-> !monitor_output_oe_out)
        else $error("monitor driven when off");
endmodule
bind synth_serial_load_port port_checker chk_i (.*);

// *** verification/serial_host_model.sv ***
// Behavioural host driving the three serial lines
`timescale 1ns/1ps
module serial_host_model (
    input  wire clk_in,
    output reg  sclk_out,
    output reg  sdata_out,
    output reg  strobe_out
);
    integer i;
    initial
    begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        strobe_out = 1'b0;
    end
    // Exactly 24 bits, MSB first, then one strobe pulse
    task send(input [23:0] w);
        begin
            for (i = 23; i >= 0; i = i - 1)
            begin
                sdata_out <= w[i];
                repeat (4) @(posedge clk_in);
                sclk_out <= 1'b1;
                repeat (4) @(posedge clk_in);
                sclk_out <= 1'b0;
            end
            sdata_out <= ~w[0]; // Released line must not keep the last bit
            repeat (4) @(posedge clk_in);
            strobe_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            strobe_out <= 1'b0;
        end
    endtask
endmodule

// *** verification/synth_serial_load_port_tb.sv ***
// Self-checking bench for the serial load port
`timescale 1ns/1ps
module synth_serial_load_port_tb;
    reg ref_clk_in = 1'b0, rst_n_in = 1'b0, chip_enable_in = 1'b1, lock_detect_in = 1'b1;
    reg analog_lock_in = 1'b1, rf_div_in = 1'b1, ref_div_in = 1'b0, pump_up_in = 1'b1, pump_dn_in = 1'b0;
    wire serial_clk_in, serial_data_in, load_strobe_in, monitor_output_out, monitor_output_oe_out;
    wire charge_pump_output_out, charge_pump_output_oe_out, powered_up_out, band_select_start_out;
    wire [23:0] control_word_out, ref_count_word_out, fb_count_word_out;
    integer miscompares = 0, num_checks = 0, bands = 0, cycles = 0, m;
    synth_serial_load_port dut (.*);
    serial_host_model host (.clk_in(ref_clk_in), .sclk_out(serial_clk_in), .sdata_out(serial_data_in),
        .strobe_out(load_strobe_in));
    initial
    begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // Count band pulses; a hang is cut short here
    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (band_select_start_out === 1'b1) bands <= bands + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            stop_test;
        end
    end
    task chk(input [23:0] got, input [23:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [23:0] w);
        begin
            host.send(w);
            repeat (8) @(posedge ref_clk_in);
        end
    endtask
    task t_order;
        begin
            wr(24'h123455);
            chk(ref_count_word_out, 24'h123455);
            chk(control_word_out, 24'h0);
            wr(24'h0000e0);
            chk(control_word_out, 24'h0000e0);
            wr(24'habcde6);
            chk(fb_count_word_out, 24'habcde6);
            chk(bands, 1);
            wr(24'hfedcbb); // Test latch on purpose
            chk(control_word_out ^ ref_count_word_out ^ fb_count_word_out, 24'hb9f953);
        end
    endtask
    task t_mux;
        begin
            for (m = 0; m < 8; m = m + 1)
            begin
                wr({16'h0, m[2:0], 5'h0});
                chk(monitor_output_oe_out, m != 0 && m != 5);
                if (m != 0 && m != 5) chk(monitor_output_out, m > 0 && m < 4);
            end
        end
    endtask
    task t_power;
        begin
            chk({powered_up_out, charge_pump_output_oe_out, charge_pump_output_out}, 3'h7);
            pump_up_in <= 1'b0;
            pump_dn_in <= 1'b1;
            repeat (3) @(posedge ref_clk_in);
            chk({charge_pump_output_oe_out, charge_pump_output_out}, 2'h2);
            pump_up_in <= 1'b1;
            repeat (3) @(posedge ref_clk_in);
            chk(charge_pump_output_oe_out, 0);
            pump_dn_in <= 1'b0;
            chip_enable_in <= 1'b0;
            repeat (8) @(posedge ref_clk_in);
            chk({powered_up_out, charge_pump_output_oe_out}, 2'h0);
            chip_enable_in <= 1'b1;
            wr(24'h1000e0);
            chk(powered_up_out, 0);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        t_order;
        t_mux;
        t_power;
        stop_test;
    end
endmodule
